// ### hdl/timer_counter_pkg.sv
// Purpose: shared constants and types for the 8-bit timer/counter control block
// Assumes: mclk is the high-frequency clock that feeds the prescaler
// Notes: register indices are word indices on the plain register port

package timer_counter_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [1:0] CONTROL_OFFSET = 2'h0;
    localparam logic [1:0] CAPTURE_A_OFFSET = 2'h1;
    localparam logic [1:0] CAPTURE_B_OFFSET = 2'h2;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CAPTURE_A_RESET = 8'hff;
    localparam logic [7:0] CAPTURE_B_RESET = 8'hff;
    // bits 5 and 7 are don't-care on read; they return zero here
    localparam logic [7:0] CONTROL_READ_MASK = 8'h5f;
    localparam logic [7:0] COUNT_FULL = 8'hff;
    localparam logic [7:0] COUNT_ZERO = 8'h00;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [2:0] CLOCK_SEL_EXTERNAL = 3'h7;
    localparam logic MODE_TIMER = 1'b0;
    localparam logic MODE_CAPTURE = 1'b1;
    // divisor exponent for clock select code zero with the stage bit clear
    localparam logic [3:0] SLOWEST_DIV_EXP = 4'hd;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic spare_hi;
        logic auto_capture_enable;
        logic spare_lo;
        logic timer_run_bit;
        logic [2:0] timer_clock_select;
        logic timer_mode_select;
    } control_type;

    typedef enum logic [2:0] {
        ST_STOPPED = 3'b001,
        ST_COUNTING = 3'b010,
        ST_HELD = 3'b100
    } run_state_type;

    // each higher select code halves the divisor, the stage bit doubles it
    function automatic logic [3:0] div_exponent(input logic [2:0] sel, input logic stage);
        div_exponent = SLOWEST_DIV_EXP - {1'b0, sel} + {3'h0, stage};
    endfunction

endpackage

// ### hdl/timer_prescaler.sv
// Purpose: free-running divider that produces the internal source-clock tick
// Assumes: one tick is one mclk cycle wide
// Notes: the divider never stops, so a tick phase is not tied to the start

module timer_prescaler
    import timer_counter_pkg::*;
#(
    parameter int WIDTH = 15
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // selection
    input wire logic [2:0] clock_select,
    input wire logic stage_select,
    // tick out
    output logic tick
);

    logic [WIDTH-1:0] div_q;
    logic [WIDTH-1:0] div_d;
    logic [WIDTH-1:0] mask;

    always_comb
    begin
        div_d = div_q + WIDTH'(1);
        mask = (WIDTH'(1) << div_exponent(clock_select, stage_select)) - WIDTH'(1);
        tick = ((div_q & mask) == mask);
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            div_q <= '0;
        end
        else
        begin
            div_q <= div_d;
        end
    end

endmodule

// ### hdl/pin_edge_detect.sv
// Purpose: rising and falling edge pulses of the timer input pin
// Assumes: the pin is synchronous to mclk
// Notes: each pulse lasts one mclk cycle

module pin_edge_detect
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // pin
    input wire logic pin,
    // edges
    output logic rise,
    output logic fall
);

    logic prev_q;
    logic prev_d;

    always_comb
    begin
        prev_d = pin;
        rise = pin & ~prev_q;
        fall = ~pin & prev_q;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            prev_q <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
        end
    end

endmodule

// ### hdl/timer_counter_8bit_control.sv
// Purpose: control, counting and capture logic of an 8-bit timer/counter
// Assumes: mclk is the high-frequency clock; inputs are synchronous to mclk
// Notes: registers sit on a plain port, read data follow one cycle later
//
// Contract
// - There is one control register and two 8-bit timer registers for compare and capture.
// - Writing 0 to the run bit stops the timer and clears the counter, writing 1 starts it.
// - Select codes 0 to 6 divide the fast clock by powers of two, the stage bit doubles them.
// - Select code 7 counts pulses from the external timer input pin; in capture mode code 7 counts prescaler ticks instead.
// - Mode 0 is timer or event counting, mode 1 is capture.
// - Auto capture copies the running count into register B, outside capture mode only.
// - Bits 5 and 7 of the control register read as don't care.
// - Entering the stop state clears the run bit and halts the timer.
// - In timer mode a match with register A raises the interrupt and clears the counter.
// - In event mode the counter advances on each rising edge of the input pin.
// - In capture mode a falling edge captures into B, a rising edge into A with interrupt.
//
// Local design decisions: the address map and the plain strobed port.

module timer_counter_8bit_control
    import timer_counter_pkg::*;
#(
    parameter int DATA_WIDTH = 8,
    parameter int PRESCALE_WIDTH = 15
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_WIDTH-1:0] reg_rdata,
    // system controls
    input wire logic stop_mode_enter,
    input wire logic divider_stage_select,
    // external pulse source
    input wire logic timer_input_pin,
    // events
    output logic timer_interrupt
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    control_type ctrl_q;
    control_type ctrl_d;
    logic [DATA_WIDTH-1:0] cnt_q;
    logic [DATA_WIDTH-1:0] cnt_d;
    logic [DATA_WIDTH-1:0] reg_a_q;
    logic [DATA_WIDTH-1:0] reg_a_d;
    logic [DATA_WIDTH-1:0] reg_b_q;
    logic [DATA_WIDTH-1:0] reg_b_d;
    logic [DATA_WIDTH-1:0] rdata_q;
    logic [DATA_WIDTH-1:0] rdata_d;
    logic irq_q;
    logic irq_d;
    run_state_type state_q;
    run_state_type state_d;

    logic presc_tick;
    logic pin_rise;
    logic pin_fall;
    logic external;
    logic src_tick;
    logic match;

    // ------------------------------------------------------------
    // source clock
    // ------------------------------------------------------------
    timer_prescaler #(
        .WIDTH(PRESCALE_WIDTH)
    ) u_prescaler (
        .mclk(mclk),
        .reset(reset),
        .clock_select(ctrl_q.timer_clock_select),
        .stage_select(divider_stage_select),
        .tick(presc_tick)
    );

    pin_edge_detect u_edges (
        .mclk(mclk),
        .reset(reset),
        .pin(timer_input_pin),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    always_comb
    begin
        external = (ctrl_q.timer_clock_select == CLOCK_SEL_EXTERNAL);
        // capture mode measures the pin against the internal clock only
        src_tick = (external && ctrl_q.timer_mode_select == MODE_TIMER) ? pin_rise
                                                                         : presc_tick;
        match = (cnt_q == reg_a_q);
    end

    // write decode shared by the control and register A groups;
    // register B takes no software writes, so a stray write there
    // is simply dropped
    function automatic logic write_hit(input logic strobe, input logic [1:0] addr,
                                       input logic [1:0] index);
        write_hit = strobe && (addr == index);
    endfunction

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // mode and select writes are taken even while running; keeping
    // them still then is up to software, the counter does not guard
    // against a select change in mid-count
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (write_hit(reg_write, reg_addr, CONTROL_OFFSET))
        begin
            ctrl_d = control_type'(reg_wdata);
        end
        // stop entry wins over a write in the same cycle
        if (stop_mode_enter)
        begin
            ctrl_d.timer_run_bit = 1'b0;
        end
    end

    // spare bits are stored as written, only the read path hides them;
    // this keeps the register a plain copy of the write data
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ctrl_q <= control_type'(CONTROL_RESET);
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------
    // registers, counting and capture
    // ------------------------------------------------------------
    always_comb
    begin
        cnt_d = cnt_q;
        reg_a_d = reg_a_q;
        reg_b_d = reg_b_q;
        irq_d = 1'b0;
        state_d = state_q;

        // software writes; hardware updates below take precedence
        if (write_hit(reg_write, reg_addr, CAPTURE_A_OFFSET))
        begin
            reg_a_d = reg_wdata;
        end

        case (state_q)
            ST_STOPPED:
            begin
                cnt_d = COUNT_ZERO;
                if (ctrl_q.timer_run_bit)
                begin
                    state_d = ST_COUNTING;
                end
            end
            ST_COUNTING,
            ST_HELD:
            begin
                if (!ctrl_q.timer_run_bit)
                begin
                    state_d = ST_STOPPED;
                    cnt_d = COUNT_ZERO;
                end
                else if (ctrl_q.timer_mode_select == MODE_TIMER)
                begin
                    // event counting checks the match on the falling edge
                    if (external && pin_fall && match)
                    begin
                        cnt_d = COUNT_ZERO;
                        irq_d = 1'b1;
                    end
                    else if (!external && presc_tick && match)
                    begin
                        cnt_d = COUNT_ZERO;
                        irq_d = 1'b1;
                    end
                    else if (src_tick)
                    begin
                        cnt_d = cnt_q + DATA_WIDTH'(1);
                    end
                    // the zero right after a match is not copied
                    if (ctrl_q.auto_capture_enable && cnt_q != COUNT_ZERO)
                    begin
                        reg_b_d = cnt_q;
                    end
                end
                else
                begin
                    if (state_q == ST_COUNTING && pin_rise)
                    begin
                        reg_a_d = cnt_q;
                        irq_d = 1'b1;
                        cnt_d = COUNT_ZERO;
                    end
                    else if (state_q == ST_COUNTING && presc_tick && cnt_q == COUNT_FULL)
                    begin
                        // overflow freezes capture until register A is read
                        reg_a_d = COUNT_FULL;
                        irq_d = 1'b1;
                        cnt_d = COUNT_ZERO;
                        state_d = ST_HELD;
                    end
                    else
                    begin
                        if (state_q == ST_COUNTING && pin_fall)
                        begin
                            reg_b_d = cnt_q;
                        end
                        if (presc_tick)
                        begin
                            cnt_d = cnt_q + DATA_WIDTH'(1);
                        end
                    end
                    if (state_q == ST_HELD && reg_read && reg_addr == CAPTURE_A_OFFSET)
                    begin
                        state_d = ST_COUNTING;
                    end
                end
            end
            default:
            begin
                state_d = ST_STOPPED;
                cnt_d = COUNT_ZERO;
            end
        endcase
    end

    // counter, compare and capture state switch together, so a capture
    // and the clear that goes with it can never land in different cycles
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cnt_q <= COUNT_ZERO;
            reg_a_q <= CAPTURE_A_RESET;
            reg_b_q <= CAPTURE_B_RESET;
            irq_q <= 1'b0;
            state_q <= ST_STOPPED;
        end
        else
        begin
            cnt_q <= cnt_d;
            reg_a_q <= reg_a_d;
            reg_b_q <= reg_b_d;
            irq_q <= irq_d;
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // zero outside the answer cycle, so several slaves can share one
    // or-tree; the spare control bits read as zero, not as written,
    // so software never sees a stale don't-care pattern
    always_comb
    begin
        rdata_d = '0;
        if (reg_read)
        begin
            case (reg_addr)
                CONTROL_OFFSET: rdata_d = ctrl_q & CONTROL_READ_MASK;
                CAPTURE_A_OFFSET: rdata_d = reg_a_q;
                CAPTURE_B_OFFSET: rdata_d = reg_b_q;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign timer_interrupt = irq_q;

endmodule

// ### verification/timer_counter_8bit_control_assertions.sv
// Purpose: port-level checks of the timer control block
// Assumes: one mclk domain, synchronous reset
// Notes: don't-care control bits are expected to read zero
module timer_checker
    import timer_counter_pkg::*;
#(
    parameter int DATA_WIDTH = 8
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_WIDTH-1:0] reg_rdata,
    // events
    input wire logic stop_mode_enter,
    input wire logic timer_interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_rd_idle;
        !$past(reg_read) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_ctl_mask;
        reg_read && reg_addr == CONTROL_OFFSET |=> !reg_rdata[7] && !reg_rdata[5];
    endproperty
    a_ctl_mask: assert property (p_ctl_mask)
        else $error("spare control bits not zero");
    property p_unmapped;
        reg_read && reg_addr == 2'h3 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_irq_pulse;
        timer_interrupt |=> !timer_interrupt;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt longer than a cycle");
    property p_stopped_quiet;
        reg_write && reg_addr == CONTROL_OFFSET && !reg_wdata[4] ##1 (!reg_write) [*4]
            |-> !timer_interrupt;
    endproperty
    a_stopped_quiet: assert property (p_stopped_quiet)
        else $error("interrupt while stopped");
    property p_stop_mode;
        stop_mode_enter ##1 (reg_read && reg_addr == CONTROL_OFFSET) |=> !reg_rdata[4];
    endproperty
    a_stop_mode: assert property (p_stop_mode)
        else $error("run bit survives stop state");
    property p_readback;
        reg_write && reg_addr == CONTROL_OFFSET && !stop_mode_enter
            ##1 reg_read && reg_addr == CONTROL_OFFSET
            |=> reg_rdata == ($past(reg_wdata, 2) & 8'h5f);
    endproperty
    a_readback: assert property (p_readback)
        else $error("control readback differs");
    property p_reset_quiet;
        $fell(reset) |-> !timer_interrupt && reg_rdata == 8'h00;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs busy after reset");
endmodule

// ### verification/pulse_source.sv
// Purpose: pulse source on the timer input pin
// Assumes: pin idles low between pulses
// Notes: high time is set per pulse, low time by the caller's gap
module pulse_source
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // request
    input wire logic fire,
    input wire logic [15:0] high_len,
    // pin
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] left_q;
    always_ff @(posedge mclk)
        if (reset)
            left_q <= 16'h0000;
        else if (fire)
            left_q <= high_len;
        else if (left_q != 16'h0000)
            left_q <= left_q - 16'h0001;
    assign pin = (left_q != 16'h0000);
endmodule

// ### verification/timer_counter_8bit_control_tb_top.sv
// Purpose: self-checking bench of the timer control block
// Assumes: mclk 125 MHz feeds the prescaler
// Notes: slow codes only get a first-interrupt bound, keeping the run short
module timer_counter_8bit_control_tb_top
    import timer_counter_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, reset, reg_write, reg_read, stop_mode_enter, divider_stage_select;
    logic timer_input_pin, timer_interrupt, fire;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic [15:0] high_len;
    int fail_count = 0;
    int check_count = 0;
    int irq_total = 0;
    timer_counter_8bit_control i_timer_counter_8bit_control (.mclk(mclk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .stop_mode_enter(stop_mode_enter),
        .divider_stage_select(divider_stage_select), .timer_input_pin(timer_input_pin),
        .timer_interrupt(timer_interrupt));
    pulse_source i_pulse_source (.mclk(mclk), .reset(reset), .fire(fire),
        .high_len(high_len), .pin(timer_input_pin));
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (timer_interrupt === 1'b1)
            irq_total <= irq_total + 1;
    // ----------
    // bus and helpers
    // ----------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    // may follow wr with no gap: it drives only the read strobe and the address
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic wait_irq(input int limit, output int n);
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (timer_interrupt !== 1'b1 && n < limit);
        if (timer_interrupt !== 1'b1)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, timer_interrupt, 1'b1);
            tally_and_finish();
        end
    endtask
    task automatic pulse(input logic [15:0] h);
        @(posedge mclk);
        fire <= 1'b1;
        high_len <= h;
        @(posedge mclk);
        fire <= 1'b0;
        repeat (h + 16'h0010) @(posedge mclk);
        #1;
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_reset;
        rd(CONTROL_OFFSET, v);
        check(v, 8'h00);
        rd(CAPTURE_A_OFFSET, v);
        check(v, 8'hff);
        rd(2'h3, v);
        check(v, 8'h00);
        wr(CONTROL_OFFSET, 8'hae);
        rd(CONTROL_OFFSET, v);
        check(v, 8'h0e);
        wr(CAPTURE_B_OFFSET, 8'h55);
        rd(CAPTURE_B_OFFSET, v);
        check(v, 8'hff);
        wr(CONTROL_OFFSET, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_timer(input logic [2:0] s, input logic g);
        int d;
        int n;
        d = 1 << (13 - s + g);
        divider_stage_select <= g;
        wr(CONTROL_OFFSET, {4'h0, s, MODE_TIMER});
        wr(CAPTURE_A_OFFSET, 8'h02);
        wr(CONTROL_OFFSET, {4'h1, s, MODE_TIMER});
        wait_irq(3 * d + 8, n);
        if (s >= 3'h3)
        begin
            wait_irq(3 * d + 8, n);
            check(n, 3 * d);
        end
        wr(CONTROL_OFFSET, 8'h00);
        $display("timer code %0d stage %0d done", s, g);
    endtask
    task automatic t_event;
        int k;
        wr(CONTROL_OFFSET, {4'h0, CLOCK_SEL_EXTERNAL, MODE_TIMER});
        wr(CAPTURE_A_OFFSET, 8'h03);
        wr(CONTROL_OFFSET, {4'h5, CLOCK_SEL_EXTERNAL, MODE_TIMER});
        k = irq_total;
        pulse(16'h0008);
        pulse(16'h0008);
        rd(CAPTURE_B_OFFSET, v);
        check(v, 8'h02);
        pulse(16'h0008);
        check(irq_total, k + 1);
        wr(CONTROL_OFFSET, 8'h00);
        $display("event test done");
    endtask
    // auto capture is left on to show it has no effect in this mode
    task automatic t_capture;
        int k;
        divider_stage_select <= 1'b0;
        wr(CONTROL_OFFSET, 8'h0d);
        wr(CONTROL_OFFSET, 8'h5d);
        k = irq_total;
        pulse(16'h0501);
        repeat (16'h0280) @(posedge mclk);
        rd(CAPTURE_B_OFFSET, v);
        check(v inside {[8'h09:8'h0b]}, 1'b1);
        check(irq_total, k + 1);
        // second rise lands 15 or 16 ticks after the first, by prescaler phase
        pulse(16'h0010);
        rd(CAPTURE_A_OFFSET, v);
        check(v inside {[8'h0e:8'h11]}, 1'b1);
        check(irq_total, k + 2);
        wr(CONTROL_OFFSET, 8'h00);
        $display("capture test done");
    endtask
    task automatic t_stop;
        int n;
        int k;
        wr(CONTROL_OFFSET, 8'h0c);
        wr(CAPTURE_A_OFFSET, 8'h02);
        wr(CONTROL_OFFSET, 8'h1c);
        wait_irq(32'h0000_0190, n);
        @(posedge mclk);
        stop_mode_enter <= 1'b1;
        @(posedge mclk);
        stop_mode_enter <= 1'b0;
        rd(CONTROL_OFFSET, v);
        check(v, 8'h0c);
        k = irq_total;
        wr(CONTROL_OFFSET, 8'h0c);
        repeat (32'h0000_0400) @(posedge mclk);
        #1;
        check(irq_total, k);
        wr(CONTROL_OFFSET, 8'h1c);
        wait_irq(32'h0000_0190, n);
        check(n > 32'h0000_00ff, 1'b1);
        wr(CONTROL_OFFSET, 8'h00);
        $display("stop test done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        reset = 1'b1;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        stop_mode_enter = 1'b0;
        divider_stage_select = 1'b0;
        fire = 1'b0;
        high_len = 16'h0000;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_reset();
        for (int s = 0; s < 7; s++)
            t_timer(s[2:0], 1'b0);
        t_timer(3'h6, 1'b1);
        t_event();
        t_capture();
        t_stop();
        tally_and_finish();
    end
endmodule
bind timer_counter_8bit_control timer_checker #(.DATA_WIDTH(DATA_WIDTH)) i_timer_checker (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .stop_mode_enter(stop_mode_enter), .timer_interrupt(timer_interrupt));
